/* File: rtl/bcrc_byte_step.v */
// Purpose: Folds one byte into a 16-bit CRC, fully unrolled
// Assumes: Pure combinational, settles within one clock
// Notes:   MSB-first, zero fed into the LSB
`timescale 1ns/1ps
`default_nettype none
`include "bcrc_defines.vh"

module bcrc_byte_step (
    input  wire [15:0] currentSum,
    input  wire [7:0]  dataByte,
    input  wire        polySelect,
    output wire [15:0] nextSum
);

    wire [15:0] polynomial_select;
    wire [15:0] stage [0:`BCRC_BITS_PER_BYTE];

    // ------------------------------------------------------------
    // Generator choice, only two fixed values
    // ------------------------------------------------------------
    assign polynomial_select = polySelect ? `BCRC_POLYNOMIAL_SELECT_CRC16 : `BCRC_POLYNOMIAL_SELECT_CCITT;

    // Byte into high half, low half kept
    assign stage[0] = {currentSum[15:8] ^ dataByte, currentSum[7:0]};

    genvar i;
    generate
        for (i = 0; i < `BCRC_BITS_PER_BYTE; i = i + 1) begin : gStep
            // Test the bit that leaves, shift, then conditional XOR
            assign stage[i+1] = {stage[i][14:0], 1'b0} ^
                (stage[i][15] ? polynomial_select : 16'h0000);
        end
    endgenerate

    assign nextSum = stage[`BCRC_BITS_PER_BYTE];

endmodule
`default_nettype wire

/* File: rtl/bcrc_defines.vh */
// Purpose: Constants for the byte-serial CRC-16 unit
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes:   Offsets are byte addresses
`ifndef BCRC_DEFINES_VH
`define BCRC_DEFINES_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define BCRC_OFF_INPUT    4'h0
`define BCRC_OFF_LOW      4'h4
`define BCRC_OFF_HIGH     4'h8
`define BCRC_OFF_CONTROL  4'hC

// ------------------------------------------------------------
// Fields, reset values and polynomials
// ------------------------------------------------------------
`define BCRC_POLYNOMIAL_SELECT_SEL_BIT 0
`define BCRC_RESET_BYTE   8'h00
`define BCRC_POLYNOMIAL_SELECT_CCITT   16'h1021
`define BCRC_POLYNOMIAL_SELECT_CRC16   16'h8005
`define BCRC_BITS_PER_BYTE 8

// ------------------------------------------------------------
// Bus answers
// ------------------------------------------------------------
`define BCRC_RESP_OKAY    2'b00
`define BCRC_RESP_SLVERR  2'b10

`endif

/* File: rtl/bcrc_top.v */
// Purpose: Byte-serial CRC-16 unit behind an AXI4-Lite slave
// Assumes: Single 200 MHz clock, software feeds bytes by register write
// Notes:   Update lands in the same edge that takes the byte write
//
// ------------------------------------------------------------
// ------------------------------------------------------------
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "bcrc_defines.vh"

module bcrc_top (
    input  wire        clock,
    input  wire        reset_n,
    // Write address
    input  wire [3:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // Write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // Write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // Read address
    input  wire [3:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // Read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    reg resetSync1;
    reg resetSync2;

    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            resetSync1 <= 1'b0;
            resetSync2 <= 1'b0;
        end else begin
            resetSync1 <= 1'b1;
            resetSync2 <= resetSync1;
        end
    end

    wire rstn;
    assign rstn = resetSync2;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    reg  [7:0]  byteInput;
    reg  [7:0]  checksumLow;
    reg  [7:0]  checksumHigh;
    reg         polySelect;
    wire [15:0] foldedSum;

    bcrc_byte_step uStep (
        .currentSum (({checksumHigh, checksumLow})),
        .dataByte   (s_axi_wdata[7:0]),
        .polySelect (polySelect),
        .nextSum    (foldedSum)
    );

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    // Address and data are latched independently so either may come
    // first; a new write is not taken until the response is gone.
    reg        awHeld;
    reg        wHeld;
    reg [3:0]  awAddr;
    reg [31:0] wData;
    reg [3:0]  wStrb;

    wire awTake;
    wire wTake;
    wire doWrite;
    wire [3:0]  curAddr;
    wire [31:0] curData;
    wire [3:0]  curStrb;

    assign awTake  = s_axi_awvalid && s_axi_awready;
    assign wTake   = s_axi_wvalid && s_axi_wready;
    assign curAddr = awHeld ? awAddr : s_axi_awaddr;
    assign curData = wHeld ? wData : s_axi_wdata;
    assign curStrb = wHeld ? wStrb : s_axi_wstrb;
    assign doWrite = (awHeld || awTake) && (wHeld || wTake) &&
                     !s_axi_bvalid;

    // Fold uses the held data byte when data arrived first
    wire [15:0] foldedHeld;

    bcrc_byte_step uStepHeld (
        .currentSum (({checksumHigh, checksumLow})),
        .dataByte   (wData[7:0]),
        .polySelect (polySelect),
        .nextSum    (foldedHeld)
    );

    wire [15:0] foldedUse;
    assign foldedUse = wHeld ? foldedHeld : foldedSum;

    wire mapped;
    assign mapped = (curAddr[1:0] == 2'b00);

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BCRC_RESP_OKAY;
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= 4'h0;
            wData         <= 32'h0000_0000;
            wStrb         <= 4'h0;
        end else begin
            // Both readies stay low while an answer is still waiting
            s_axi_awready <= !awHeld && !awTake && !doWrite &&
                             !s_axi_bvalid;
            s_axi_wready  <= !wHeld && !wTake && !doWrite &&
                             !s_axi_bvalid;
            if (awTake && !doWrite) begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (wTake && !doWrite) begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld        <= 1'b0;
                wHeld         <= 1'b0;
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= mapped ? `BCRC_RESP_OKAY
                                        : `BCRC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= !awHeld;
                s_axi_wready  <= !wHeld;
            end
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            byteInput    <= `BCRC_RESET_BYTE;
            checksumLow  <= `BCRC_RESET_BYTE;
            checksumHigh <= `BCRC_RESET_BYTE;
            polySelect   <= 1'b0;
        end else if (doWrite && curStrb[0]) begin
            case (curAddr)
                `BCRC_OFF_INPUT: begin
                    byteInput    <= curData[7:0];
                    // Result stored on the taking edge
                    checksumHigh <= foldedUse[15:8];
                    checksumLow  <= foldedUse[7:0];
                end
                `BCRC_OFF_LOW: begin
                    checksumLow <= curData[7:0];
                end
                `BCRC_OFF_HIGH: begin
                    checksumHigh <= curData[7:0];
                end
                `BCRC_OFF_CONTROL: begin
                    polySelect <= curData[`BCRC_POLYNOMIAL_SELECT_SEL_BIT];
                end
                default: begin
                    byteInput <= byteInput;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    reg [31:0] readWord;
    reg        readOk;

    always @* begin
        readWord = 32'h0000_0000;
        readOk   = 1'b1;
        case (s_axi_araddr)
            `BCRC_OFF_INPUT:   readWord = {24'h00_0000, byteInput};
            `BCRC_OFF_LOW:     readWord = {24'h00_0000, checksumLow};
            `BCRC_OFF_HIGH:    readWord = {24'h00_0000, checksumHigh};
            // Upper control bits are not stored at all
            `BCRC_OFF_CONTROL: readWord = {31'h0000_0000, polySelect};
            default:           readOk   = 1'b0;
        endcase
    end

    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `BCRC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= readWord;
                s_axi_rresp   <= readOk ? `BCRC_RESP_OKAY
                                        : `BCRC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end else begin
                s_axi_arready <= !s_axi_rvalid;
            end
        end
    end

endmodule
`default_nettype wire

/* File: sim/bcrc_properties.sv */
// Purpose: Port checks on bcrc_top
// Assumes: Registered AXI4-Lite answers one cycle after a take
// Notes:   Read address kept here to judge the data that follows
`timescale 1ns/1ps
`default_nettype none
`include "bcrc_defines.vh"
module bcrc_checker (
    input wire logic        clock,
    input wire logic        reset_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    // ------------------------------------------------------------
    // Read address capture and handshakes
    // ------------------------------------------------------------
    logic [3:0] rdAddr;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n)
            rdAddr <= 4'h0;
        else if (s_axi_arvalid && s_axi_arready)
            rdAddr <= s_axi_araddr;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    sequence wrTake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rdTake;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (wrTake |=> s_axi_bvalid)
        else $error("write answer missing");
    a_read_answer: assert property (rdTake |=> s_axi_rvalid)
        else $error("read answer missing");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
    a_ctrl_upper_zero: assert property (s_axi_rvalid
        && rdAddr == `BCRC_OFF_CONTROL |-> s_axi_rdata[31:1] == 31'h0)
        else $error("control upper bits set");
    a_byte_regs_narrow: assert property (s_axi_rvalid
        && rdAddr != `BCRC_OFF_CONTROL |-> s_axi_rdata[31:8] == 24'h0)
        else $error("byte register too wide");
    a_no_write_overlap: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
    a_bad_read_err: assert property (s_axi_rvalid && rdAddr[1:0] != 2'b00
        |-> s_axi_rresp == `BCRC_RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("misaligned read accepted");
endmodule
bind bcrc_top bcrc_checker bcrc_checker_i (.*);
`default_nettype wire

/* File: sim/bcrc_top_bench.sv */
// Purpose: Self-checking bench for bcrc_top
// Assumes: Checksum readable at the read after the byte write
// Notes:   Ready lines stall at random to exercise held answers
`timescale 1ns/1ps
`default_nettype none
`include "bcrc_defines.vh"
module bcrc_top_bench;
    logic        clock, reset_n, pol;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready;
    logic [2:0]  s_axi_awprot, s_axi_arprot;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, got, v;
    logic [15:0] cur;
    logic [1:0]  resp;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire         s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    integer      seed, fails, compares, cycles, i, k;
    bcrc_top bcrc_top_i (.*);
    always #2.5 clock = ~clock;
    // ------------------------------------------------------------
    // Reference, bus tasks and report
    // ------------------------------------------------------------
    function logic [15:0] crcf(input logic [15:0] c, input logic [7:0] b,
                               input logic q);
        logic [15:0] t;
        t = c ^ {b, 8'h00};
        for (int n = 0; n < 8; n++)
            t = t[15] ? (t << 1) ^ (q ? 16'h8005 : 16'h1021) : t << 1;
        return t;
    endfunction
    task summarize;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares = compares + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        if ($random(seed) & 1) @(posedge clock);
        s_axi_bready <= 1'b1;
        @(posedge clock);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (!s_axi_rvalid);
        if ($random(seed) & 1) @(posedge clock);
        s_axi_rready <= 1'b1;
        @(posedge clock);
        got = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task rdChk(input logic [3:0] a, input logic [31:0] e);
        rd(a);
        chk(got, e);
        chk({30'h0, resp}, {30'h0, `BCRC_RESP_OKAY});
    endtask
    task setup(input logic q, input logic [15:0] c);
        pol = q;
        cur = c;
        wr(`BCRC_OFF_CONTROL, {31'h0, q}, 4'h1);
        wr(`BCRC_OFF_LOW, {24'h0, c[7:0]}, 4'h1);
        wr(`BCRC_OFF_HIGH, {24'h0, c[15:8]}, 4'h1);
    endtask
    task feed(input logic [7:0] b);
        wr(`BCRC_OFF_INPUT, {24'h0, b}, 4'h1);
        chk({30'h0, resp}, {30'h0, `BCRC_RESP_OKAY});
        cur = crcf(cur, b, pol);
        rdChk(`BCRC_OFF_LOW, {24'h0, cur[7:0]});
        rdChk(`BCRC_OFF_HIGH, {24'h0, cur[15:8]});
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            summarize;
        end
    end
    initial begin
        {clock, reset_n, pol, cur, got, v, resp} = '0;
        {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb,
         s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot,
         s_axi_arvalid, s_axi_rready} = '0;
        seed = 81790;
        fails = 0;
        compares = 0;
        cycles = 0;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        rdChk(`BCRC_OFF_INPUT, 32'h0);
        rdChk(`BCRC_OFF_LOW, 32'h0);
        rdChk(`BCRC_OFF_HIGH, 32'h0);
        rdChk(`BCRC_OFF_CONTROL, 32'h0);
        wr(`BCRC_OFF_CONTROL, 32'hFFFF_FFFF, 4'hF);
        rdChk(`BCRC_OFF_CONTROL, 32'h1);
        wr(`BCRC_OFF_CONTROL, 32'h0, 4'hE);
        rdChk(`BCRC_OFF_CONTROL, 32'h1);
        wr(4'h2, 32'h0, 4'hF);
        chk({30'h0, resp}, {30'h0, `BCRC_RESP_SLVERR});
        rd(4'h6);
        chk({30'h0, resp}, {30'h0, `BCRC_RESP_SLVERR});
        for (k = 0; k < 2; k++)
            for (i = 0; i < 8; i++) begin
                setup(k[0], 16'h0);
                feed(i[7:0]);
            end
        v = 32'h1234_5678;
        for (k = 0; k < 2; k++) begin
            setup(k[0], 16'h0);
            for (i = 0; i < 4; i++)
                feed(v[8 * i +: 8]);
            chk({16'h0, cur}, k ? 32'h0000_5C43 : 32'h0000_D0FA);
        end
        for (i = 0; i < 24; i++) begin
            v = $random(seed);
            if (v[20] || i == 0) setup(v[21], v[31:16]);
            feed(v[7:0]);
            feed(v[15:8]);
            rdChk(`BCRC_OFF_INPUT, {24'h0, v[15:8]});
        end
        summarize;
    end
endmodule
`default_nettype wire
